// >>> ppcm_cfg_reg.sv
// one 8-bit configuration register with bit or byte write
`timescale 1ns/1ps
`default_nettype none
module ppcm_cfg_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] IMP     = 8'hff,
  parameter bit         BIT_OK  = 1'b1
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // write side
  input  wire logic       sel,
  input  wire logic       wr_byte,
  input  wire logic       wr_bit,
  input  wire logic [2:0] bit_idx,
  input  wire logic [7:0] wdata,
  // value
  output logic      [7:0] q
);
  logic [7:0] val_reg;
  logic [7:0] val_next;
  logic [7:0] bit_mask;
  logic [7:0] merged;

  assign bit_mask = 8'h01 << bit_idx;
  assign merged   = (val_reg & ~bit_mask) | (wdata & bit_mask);
  // unimplemented bits are frozen at reset value
  assign val_next = (sel && wr_byte) ? ((wdata & IMP) | (RST_VAL & ~IMP)) :
                    (sel && wr_bit && BIT_OK) ?
                      ((merged & IMP) | (RST_VAL & ~IMP)) :
                    val_reg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      val_reg <= RST_VAL;
    else
      val_reg <= val_next;
  end

  assign q = val_reg;
endmodule
`default_nettype wire

// >>> ppcm_pkg.sv
// package: register map and reset values for port pin configuration
package ppcm_pkg;
  localparam logic [19:0] OFS_OTYPE0 = 20'hf0050;
  localparam logic [19:0] OFS_OTYPE1 = 20'hf0051;
  localparam logic [19:0] OFS_OTYPE2 = 20'hf0052;
  localparam logic [19:0] OFS_OTYPE4 = 20'hf0054;
  localparam logic [19:0] OFS_ASEL0  = 20'hf0060;
  localparam logic [19:0] OFS_ASEL2  = 20'hf0062;
  localparam logic [19:0] OFS_REDIR2 = 20'hf0075;
  localparam logic [19:0] OFS_REDIR6 = 20'hf0076;
  localparam logic [19:0] OFS_REDIR0 = 20'hf0077;
  localparam logic [19:0] OFS_REDIR1 = 20'hf0079;
  localparam logic [19:0] OFS_REDIR4 = 20'hf007b;
  localparam logic [19:0] OFS_REDIR3 = 20'hf007c;
  localparam logic [19:0] OFS_REDIR5 = 20'hf007d;
  localparam logic [7:0]  RST_OTYPE  = 8'h00;
  localparam logic [7:0]  RST_ASEL   = 8'hff;
  localparam logic [7:0]  RST_REDIR  = 8'h00;
  // implemented-bit masks (largest package)
  localparam logic [7:0]  IMP_OTYPE0 = 8'hfb;
  localparam logic [7:0]  IMP_OTYPE1 = 8'hd0;
  localparam logic [7:0]  IMP_OTYPE2 = 8'h05;
  localparam logic [7:0]  IMP_OTYPE4 = 8'h02;
  localparam logic [7:0]  IMP_ASEL0  = 8'hfe;
  localparam logic [7:0]  IMP_ASEL2  = 8'h0f;
  localparam logic [7:0]  IMP_REDIR0 = 8'h7f;
  localparam logic [7:0]  IMP_REDIR1 = 8'hff;
  localparam logic [7:0]  IMP_REDIR2 = 8'h7f;
  localparam logic [7:0]  IMP_REDIR3 = 8'h0f;
  localparam logic [7:0]  IMP_REDIR4 = 8'hff;
  localparam logic [7:0]  IMP_REDIR5 = 8'hff;
  localparam logic [7:0]  IMP_REDIR6 = 8'hff;
endpackage

// >>> ppcm_port_pin_config.sv
// top: output type, analog select and redirection registers
`timescale 1ns/1ps
`default_nettype none
module ppcm_port_pin_config (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // cpu memory access
  input  wire logic [19:0] addr,
  input  wire logic        wr_byte,
  input  wire logic        wr_bit,
  input  wire logic [2:0]  bit_idx,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  output logic             rd_hit,
  // pull-up and direction settings from the port block
  input  wire logic [7:0]  pullup_en_p0,
  input  wire logic [7:0]  pullup_en_p1,
  input  wire logic [7:0]  pullup_en_p2,
  input  wire logic [7:0]  pullup_en_p4,
  input  wire logic [7:0]  direction_port0,
  input  wire logic [7:0]  direction_port1,
  input  wire logic [7:0]  direction_port2,
  input  wire logic [7:0]  direction_port4,
  // pad controls
  output logic      [7:0]  open_drain_p0,
  output logic      [7:0]  open_drain_p1,
  output logic      [7:0]  open_drain_p2,
  output logic      [7:0]  open_drain_p4,
  output logic      [7:0]  analog_p0,
  output logic      [7:0]  analog_p2,
  output logic      [7:0]  pullup_on_p0,
  output logic      [7:0]  pullup_on_p1,
  output logic      [7:0]  pullup_on_p2,
  output logic      [7:0]  pullup_on_p4,
  // redirection selections for the function routing tables
  output logic      [55:0] redirect_sel
);
  logic       rst_s1_reg;
  logic       rst_n_reg;
  logic [7:0] regs [13];
  logic [7:0] hit;
  logic [7:0] rd_next;
  logic       rd_hit_next;
  logic [12:0] sel;
  logic [7:0] pu_on [4];

  localparam logic [19:0] OFS [13] = '{ppcm_pkg::OFS_OTYPE0,
    ppcm_pkg::OFS_OTYPE1, ppcm_pkg::OFS_OTYPE2, ppcm_pkg::OFS_OTYPE4,
    ppcm_pkg::OFS_ASEL0, ppcm_pkg::OFS_ASEL2, ppcm_pkg::OFS_REDIR0,
    ppcm_pkg::OFS_REDIR1, ppcm_pkg::OFS_REDIR2, ppcm_pkg::OFS_REDIR3,
    ppcm_pkg::OFS_REDIR4, ppcm_pkg::OFS_REDIR5, ppcm_pkg::OFS_REDIR6};
  localparam logic [7:0] IMPS [13] = '{ppcm_pkg::IMP_OTYPE0,
    ppcm_pkg::IMP_OTYPE1, ppcm_pkg::IMP_OTYPE2, ppcm_pkg::IMP_OTYPE4,
    ppcm_pkg::IMP_ASEL0, ppcm_pkg::IMP_ASEL2, ppcm_pkg::IMP_REDIR0,
    ppcm_pkg::IMP_REDIR1, ppcm_pkg::IMP_REDIR2, ppcm_pkg::IMP_REDIR3,
    ppcm_pkg::IMP_REDIR4, ppcm_pkg::IMP_REDIR5, ppcm_pkg::IMP_REDIR6};

  // reset release synchroniser; assertion stays asynchronous
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++)
    begin : g_reg
      localparam logic [7:0] RV = (gi == 4 || gi == 5) ?
        ppcm_pkg::RST_ASEL :
        ((gi < 4) ? ppcm_pkg::RST_OTYPE : ppcm_pkg::RST_REDIR);
      assign sel[gi] = (addr == OFS[gi]);
      // index 6 and up are redirection: byte writes only
      ppcm_cfg_reg #(
        .RST_VAL (RV),
        .IMP     (IMPS[gi]),
        .BIT_OK  (gi < 6)
      ) u_reg (
        .mclk    (mclk),
        .rst_n   (rst_n_reg),
        .sel     (sel[gi]),
        .wr_byte (wr_byte),
        .wr_bit  (wr_bit),
        .bit_idx (bit_idx),
        .wdata   (wdata),
        .q       (regs[gi])
      );
    end
  endgenerate

  // read mux: one-hot select, unmapped reads 00
  always_comb
  begin
    rd_next     = 8'h00;
    rd_hit_next = 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      if (sel[i])
      begin
        rd_next     = regs[i];
        rd_hit_next = 1'b1;
      end
    end
  end
  assign hit = rd_next;

  // pull-up qualifying: enabled, input, digital, push-pull
  assign pu_on[0] = pullup_en_p0 & direction_port0 & ~regs[4] & ~regs[0];
  assign pu_on[1] = pullup_en_p1 & direction_port1 & ~regs[1];
  assign pu_on[2] = pullup_en_p2 & direction_port2 & ~regs[5] & ~regs[2];
  assign pu_on[3] = pullup_en_p4 & direction_port4 & ~regs[3];
  // ports 1 and 4 have no analog function

  always_ff @(posedge mclk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rdata         <= 8'h00;
      rd_hit        <= 1'b0;
      open_drain_p0 <= ppcm_pkg::RST_OTYPE;
      open_drain_p1 <= ppcm_pkg::RST_OTYPE;
      open_drain_p2 <= ppcm_pkg::RST_OTYPE;
      open_drain_p4 <= ppcm_pkg::RST_OTYPE;
      analog_p0     <= ppcm_pkg::RST_ASEL;
      analog_p2     <= ppcm_pkg::RST_ASEL;
      pullup_on_p0  <= 8'h00;
      pullup_on_p1  <= 8'h00;
      pullup_on_p2  <= 8'h00;
      pullup_on_p4  <= 8'h00;
      redirect_sel  <= {7{ppcm_pkg::RST_REDIR}};
    end
    else
    begin
      rdata         <= rd ? hit : 8'h00;
      rd_hit        <= rd & rd_hit_next;
      // includes the I2C data pins
      open_drain_p0 <= regs[0];
      open_drain_p1 <= regs[1];
      open_drain_p2 <= regs[2];
      open_drain_p4 <= regs[3];
      analog_p0     <= regs[4];
      analog_p2     <= regs[5];
      pullup_on_p0  <= pu_on[0];
      pullup_on_p1  <= pu_on[1];
      pullup_on_p2  <= pu_on[2];
      pullup_on_p4  <= pu_on[3];
      // value 0 per field leaves the default pin
      redirect_sel  <= {regs[12], regs[11], regs[10], regs[9],
                        regs[8], regs[7], regs[6]};
    end
  end

  property p_od_no_pullup;
    @(posedge mclk) disable iff (!rst_n_reg)
      (regs[0] != 8'h00) |=> ((pullup_on_p0 & $past(regs[0])) == 8'h00);
  endproperty
  a_od_no_pullup: assert property (p_od_no_pullup)
    else $error("pull-up on open-drain pin");

  property p_analog_no_pullup;
    @(posedge mclk) disable iff (!rst_n_reg)
      ##1 ((pullup_on_p2 & analog_p2) == 8'h00);
  endproperty
  a_analog_no_pullup: assert property (p_analog_no_pullup)
    else $error("pull-up on analog pin");

  property p_redir_no_bit;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_bit && !wr_byte && sel[6]) |=> (regs[6] == $past(regs[6]));
  endproperty
  a_redir_no_bit: assert property (p_redir_no_bit)
    else $error("redirection changed by bit write");

  property p_otype_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[0]) |=> ##1
        (open_drain_p0 == ($past(wdata, 2) & ppcm_pkg::IMP_OTYPE0));
  endproperty
  a_otype_byte: assert property (p_otype_byte)
    else $error("output type byte write not seen");

  property p_asel_bit;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_bit && !wr_byte && sel[5] && bit_idx == 3'h1) |=>
        (regs[5][1] == $past(wdata[1]));
  endproperty
  a_asel_bit: assert property (p_asel_bit)
    else $error("analog select bit write lost");

  property p_asel_fixed;
    @(posedge mclk) disable iff (!rst_n_reg)
      (regs[5][7:4] == 4'hf) && (regs[4][0] == 1'b1);
  endproperty
  a_asel_fixed: assert property (p_asel_fixed)
    else $error("unimplemented analog bit not one");

  property p_reset_vals;
    @(posedge mclk) $rose(rst_n_reg) |->
      (regs[4] == 8'hff) && (regs[0] == 8'h00) && (regs[9] == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong value after reset");

  property p_redir_out;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[7]) |=> ##1
        (redirect_sel[15:8] == $past(wdata, 2));
  endproperty
  a_redir_out: assert property (p_redir_out)
    else $error("redirection output stale");

  property p_otype1_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[1]) |=> ##1
        (open_drain_p1 == ($past(wdata, 2) & ppcm_pkg::IMP_OTYPE1));
  endproperty
  a_otype1_byte: assert property (p_otype1_byte)
    else $error("output type port 1 byte write not seen");

  property p_otype2_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[2]) |=> ##1
        (open_drain_p2 == ($past(wdata, 2) & ppcm_pkg::IMP_OTYPE2));
  endproperty
  a_otype2_byte: assert property (p_otype2_byte)
    else $error("output type port 2 byte write not seen");

  property p_otype4_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[3]) |=> ##1
        (open_drain_p4 == ($past(wdata, 2) & ppcm_pkg::IMP_OTYPE4));
  endproperty
  a_otype4_byte: assert property (p_otype4_byte)
    else $error("output type port 4 byte write not seen");

  // unimplemented analog bits come back as one, not as written
  property p_asel0_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[4]) |=> ##1
        (analog_p0 == (($past(wdata, 2) & ppcm_pkg::IMP_ASEL0) |
                       ~ppcm_pkg::IMP_ASEL0));
  endproperty
  a_asel0_byte: assert property (p_asel0_byte)
    else $error("analog select port 0 byte write not seen");

  property p_asel2_byte;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_byte && sel[5]) |=> ##1
        (analog_p2 == (($past(wdata, 2) & ppcm_pkg::IMP_ASEL2) |
                       ~ppcm_pkg::IMP_ASEL2));
  endproperty
  a_asel2_byte: assert property (p_asel2_byte)
    else $error("analog select port 2 byte write not seen");

  property p_od_no_pullup_all;
    @(posedge mclk) disable iff (!rst_n_reg)
      1'b1 |=> (((pullup_on_p1 & $past(regs[1])) |
                 (pullup_on_p2 & $past(regs[2])) |
                 (pullup_on_p4 & $past(regs[3]))) == 8'h00);
  endproperty
  a_od_no_pullup_all: assert property (p_od_no_pullup_all)
    else $error("pull-up on open-drain pin of port 1, 2 or 4");

  property p_pullup_qualified;
    @(posedge mclk) disable iff (!rst_n_reg)
      1'b1 |=> ((pullup_on_p0 & ~($past(pullup_en_p0) &
                 $past(direction_port0) & ~$past(regs[4]))) == 8'h00);
  endproperty
  a_pullup_qualified: assert property (p_pullup_qualified)
    else $error("pull-up on disabled, output or analog pin");

  property p_redir_bit_all;
    @(posedge mclk) disable iff (!rst_n_reg)
      (wr_bit && !wr_byte && (sel[12:7] != 6'h00)) |=>
        ({regs[12], regs[11], regs[10], regs[9], regs[8], regs[7]} ==
         $past({regs[12], regs[11], regs[10], regs[9], regs[8], regs[7]}));
  endproperty
  a_redir_bit_all: assert property (p_redir_bit_all)
    else $error("redirection 1 to 6 changed by bit write");

  property p_asel_readback;
    @(posedge mclk) disable iff (!rst_n_reg)
      (rd && sel[5]) |=> (rd_hit && (rdata[7:4] == 4'hf));
  endproperty
  a_asel_readback: assert property (p_asel_readback)
    else $error("unimplemented analog bits not read as one");

  property p_reset_outs;
    @(posedge mclk) $rose(rst_n_reg) |->
      (redirect_sel == {7{ppcm_pkg::RST_REDIR}}) &&
      (analog_p2 == ppcm_pkg::RST_ASEL) &&
      (open_drain_p4 == ppcm_pkg::RST_OTYPE);
  endproperty
  a_reset_outs: assert property (p_reset_outs)
    else $error("pad outputs wrong after reset");

  property p_otype_fixed;
    @(posedge mclk) disable iff (!rst_n_reg)
      ((open_drain_p0 & ~ppcm_pkg::IMP_OTYPE0) == 8'h00) &&
      ((open_drain_p1 & ~ppcm_pkg::IMP_OTYPE1) == 8'h00);
  endproperty
  a_otype_fixed: assert property (p_otype_fixed)
    else $error("unimplemented output type bit not zero");
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking testbench for the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic        wr_byte = 1'b0;
  logic        wr_bit = 1'b0;
  logic [2:0]  bit_idx = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        rd = 1'b0;
  logic [7:0]  pu_en = 8'h00;
  logic [7:0]  dir = 8'h00;
  logic [7:0]  rdata, od0, od1, od2, od4, an0, an2;
  logic [7:0]  pon0, pon1, pon2, pon4;
  logic        rd_hit;
  logic [55:0] redirect_sel;
  int          errors = 0;
  int          compares = 0;
  // order: output type 0,1,2,4, analog 0,2, redirection 0..6
  logic [19:0] ra [13] = '{ppcm_pkg::OFS_OTYPE0, ppcm_pkg::OFS_OTYPE1,
    ppcm_pkg::OFS_OTYPE2, ppcm_pkg::OFS_OTYPE4, ppcm_pkg::OFS_ASEL0,
    ppcm_pkg::OFS_ASEL2, ppcm_pkg::OFS_REDIR0, ppcm_pkg::OFS_REDIR1,
    ppcm_pkg::OFS_REDIR2, ppcm_pkg::OFS_REDIR3, ppcm_pkg::OFS_REDIR4,
    ppcm_pkg::OFS_REDIR5, ppcm_pkg::OFS_REDIR6};
  logic [7:0]  rst [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  imp [13] = '{ppcm_pkg::IMP_OTYPE0, ppcm_pkg::IMP_OTYPE1,
    ppcm_pkg::IMP_OTYPE2, ppcm_pkg::IMP_OTYPE4, ppcm_pkg::IMP_ASEL0,
    ppcm_pkg::IMP_ASEL2, ppcm_pkg::IMP_REDIR0, ppcm_pkg::IMP_REDIR1,
    ppcm_pkg::IMP_REDIR2, ppcm_pkg::IMP_REDIR3, ppcm_pkg::IMP_REDIR4,
    ppcm_pkg::IMP_REDIR5, ppcm_pkg::IMP_REDIR6};

  always #20 mclk = ~mclk;

  ppcm_port_pin_config dut (
    .mclk            (mclk),
    .resetn          (resetn),
    .addr            (addr),
    .wr_byte         (wr_byte),
    .wr_bit          (wr_bit),
    .bit_idx         (bit_idx),
    .wdata           (wdata),
    .rd              (rd),
    .rdata           (rdata),
    .rd_hit          (rd_hit),
    .pullup_en_p0    (pu_en),
    .pullup_en_p1    (pu_en),
    .pullup_en_p2    (pu_en),
    .pullup_en_p4    (pu_en),
    .direction_port0 (dir),
    .direction_port1 (dir),
    .direction_port2 (dir),
    .direction_port4 (dir),
    .open_drain_p0   (od0),
    .open_drain_p1   (od1),
    .open_drain_p2   (od2),
    .open_drain_p4   (od4),
    .analog_p0       (an0),
    .analog_p2       (an2),
    .pullup_on_p0    (pon0),
    .pullup_on_p1    (pon1),
    .pullup_on_p2    (pon2),
    .pullup_on_p4    (pon4),
    .redirect_sel    (redirect_sel)
  );

  // inputs change 1 ns after the edge, never on it
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // strobe dropped for one cycle so calls can follow each other
  task automatic wr(logic [19:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr_byte = 1'b1;
    tick();
    wr_byte = 1'b0;
    tick();
  endtask

  task automatic wb(logic [19:0] a, logic [2:0] i, logic v);
    addr = a;
    bit_idx = i;
    wdata = {8{v}};
    wr_bit = 1'b1;
    tick();
    wr_bit = 1'b0;
    tick();
  endtask

  task automatic rchk(logic [19:0] a, logic [7:0] e, logic h);
    addr = a;
    rd = 1'b1;
    tick();
    cmp("rdata", e, rdata);
    cmp("rd_hit", {7'h00, h}, {7'h00, rd_hit});
    rd = 1'b0;
    tick();
  endtask

  task automatic chk_rst;
    for (int i = 0; i < 13; i++)
      rchk(ra[i], rst[i], 1'b1);
    rchk(20'hf0053, 8'h00, 1'b0);
    cmp("analog_p0", 8'hff, an0);
    cmp("open_drain_p0", 8'h00, od0);
    cmp("redirect", 8'h00, redirect_sel[7:0]);
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) tick();
    errors++;
    test_done();
  end

  initial
  begin
    repeat (2) tick();
    resetn = 1'b1;
    repeat (3) tick();
    chk_rst();
    $display("test reset values done");
    // inverse of reset everywhere: unimplemented bits must not move
    for (int i = 0; i < 13; i++)
    begin
      wr(ra[i], ~rst[i]);
      rchk(ra[i], rst[i] ^ imp[i], 1'b1);
    end
    for (int j = 0; j < 7; j++)
      cmp("redirect", imp[j+6], redirect_sel[8*j +: 8]);
    cmp("open_drain_p0", 8'hfb, od0);
    cmp("open_drain_p4", 8'h02, od4);
    cmp("open_drain_p1", 8'hd0, od1);
    cmp("open_drain_p2", 8'h05, od2);
    cmp("analog_p0", 8'h01, an0);
    cmp("analog_p2", 8'hf0, an2);
    $display("test byte writes done");
    wb(ra[0], 3'h0, 1'b0);
    wb(ra[0], 3'h2, 1'b1);
    wb(ra[4], 3'h1, 1'b1);
    wb(ra[6], 3'h0, 1'b0);
    wb(ra[5], 3'h1, 1'b1);
    wb(ra[12], 3'h7, 1'b0);
    rchk(ra[0], 8'hfa, 1'b1);
    rchk(ra[4], 8'h03, 1'b1);
    rchk(ra[6], 8'h7f, 1'b1);
    rchk(ra[5], 8'hf2, 1'b1);
    rchk(ra[12], 8'hff, 1'b1);
    $display("test bit writes done");
    pu_en = 8'hff;
    dir = 8'hff;
    repeat (2) tick();
    cmp("pullup_on_p0", 8'h04, pon0);
    cmp("pullup_on_p1", 8'h2f, pon1);
    cmp("pullup_on_p2", 8'h08, pon2);
    cmp("pullup_on_p4", 8'hfd, pon4);
    wr(ra[0], 8'h00);
    wr(ra[4], 8'h01);
    dir = 8'h0f;
    repeat (2) tick();
    cmp("pullup_on_p0", 8'h0e, pon0);
    pu_en = 8'h3c;
    repeat (2) tick();
    cmp("pullup_on_p0", 8'h0c, pon0);
    $display("test pull-up done");
    resetn = 1'b0;
    tick();
    resetn = 1'b1;
    repeat (3) tick();
    chk_rst();
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
